// ==== include/mcs_map.svh ====
`ifndef MCS_MAP_SVH
`define MCS_MAP_SVH
// Register offsets reached through the address pointer
`define MCS_OFS_POWER_TEST 8'h15
`define MCS_OFS_CHAN_MODE 8'h16
`define MCS_OFS_MAIN_CFG 8'h40
`define MCS_OFS_ALARM_1 8'h41
`define MCS_OFS_ALARM_2 8'h42
// Reset values
`define MCS_RST_PTR 8'h00
`define MCS_RST_POWER_TEST 8'h00
`define MCS_RST_CHAN_MODE 8'h00
`define MCS_RST_MAIN_CFG 8'h08
`define MCS_RST_ALARM 8'h00
// Power/test control fields
`define MCS_PT_SHUTDOWN 0
// Channel mode fields
`define MCS_CM_CH1_ANALOG 0
`define MCS_CM_CH2_ANALOG 1
`define MCS_CM_SECOND_DIODE 2
`define MCS_CM_SUPPLY_5V 3
`define MCS_CM_IRQ_EN_LO 4
`define MCS_CM_IRQ_EN_HI 6
`define MCS_CM_ID_OR_IRQ 7
// Main configuration fields
`define MCS_CFG_START 0
`define MCS_CFG_GEN_EN 1
`define MCS_CFG_THERMAL_IRQ_N_EN 2
`define MCS_CFG_GEN_CLEAR 3
`define MCS_CFG_RESET_OUT 4
`define MCS_CFG_THERMAL_IRQ_CLEAR 6
`define MCS_CFG_INIT 7
// Second alarm status fields
`define MCS_AS2_12V 0
`define MCS_AS2_CORE2 1
`define MCS_AS2_INTRUSION 4
`define MCS_AS2_THERMAL_IRQ_N_PIN 5
`define MCS_AS2_DIODE1 6
`define MCS_AS2_DIODE2 7
`define MCS_AS2_RESERVED_MASK 8'h0c
// Timing
`define MCS_CLK_HZ 10000000
`define MCS_RST_PULSE_MS 20
`define MCS_RST_PULSE_CYC ((`MCS_RST_PULSE_MS * `MCS_CLK_HZ) / 1000)
`endif

// ==== include/mcs_pkg.sv ====
package mcs_pkg;
    // Reset output pulse sequencer, one-hot
    typedef enum logic [1:0] {
        MCS_RST_IDLE = 2'b01,
        MCS_RST_PULSE = 2'b10
    } mcs_rst_state_e;
    typedef logic [7:0] mcs_byte_t;
endpackage

// ==== rtl/mcs_regs.sv ====
// Functional notes
// - Power/test bit 0 selects shutdown mode
// - Mode bits 0,1: analog input or fan
// - Mode bit 2: second supplies as diode
// - Mode bit 3: 5.0V or 3.3V scaling
// - Mode bits 4-6 enable ext irqs, need bit7
// - Mode bit 7: id inputs become irqs
// - Config bit 0 starts monitoring, else standby
// - Clearing start keeps interrupt outputs asserted
// - Config bits 1,2 enable both irq outputs
// - Config bit 3 drops general irq, halts
// - Config bit 4: reset low 20 ms, self-clears
// - Config bit 6 drops thermal irq output
// - Config bit 7 restores config and status defaults, reads zero
// - Status1 bits 0-5 latch limit violations
// - Status1 bits 6,7 fan or analog per mode
// - Status2 bits 0,1 latch; 2,3 reserved
// - Status2 bit 4 latches chassis intrusion high
// - Status2 bit 5 latches external thermal pull
// - Status2 bits 6,7 latch diode faults
// - Mask bit one blocks status from irq
// - Accesses use 8-bit pointer, resets zero
`include "mcs_map.svh"
module mcs_regs #(
    parameter int unsigned RST_PULSE_CYC = `MCS_RST_PULSE_CYC
) (
    input wire logic I_CLOCK,
    input wire logic I_ARST_N,
    input wire logic I_PTR_WE,
    input wire logic I_WR_EN,
    input wire logic [7:0] I_WR_DATA,
    input wire logic I_RD_EN,
    output logic [7:0] O_RD_DATA,
    output logic [7:0] O_PTR,
    output logic O_EXT_WR,
    input wire logic [7:0] I_EXT_RD_DATA,
    input wire logic [7:0] I_LIMIT_EVT_1,
    input wire logic [1:0] I_AIN_EVT,
    input wire logic [1:0] I_LIMIT_EVT_2,
    input wire logic [1:0] I_DIODE_FAULT,
    input wire logic [7:0] I_MASK_1,
    input wire logic [7:0] I_MASK_2,
    input wire logic I_THERMAL_IRQ_N_COND,
    input wire logic I_CHASSIS_INTRUSION,
    input wire logic I_THERMAL_IRQ_N,
    output logic O_THERMAL_IRQ_N,
    output logic O_THERMAL_IRQ_OE,
    output logic O_GENERAL_IRQ_N,
    output logic O_SYS_RESET_OUT_N,
    output logic O_INIT_PULSE,
    output logic O_SHUTDOWN,
    output logic O_MONITOR_RUN,
    output logic O_CH1_ANALOG,
    output logic O_CH2_ANALOG,
    output logic O_SECOND_DIODE,
    output logic O_SUPPLY_5V,
    output logic O_ID_OR_IRQ,
    output logic [2:0] O_EXT_IRQ_EN
);
    // Long pulse counts live in a 32-bit counter; zero would wrap the count and hold the pulse for 2^32 cycles
    if (RST_PULSE_CYC < 1) begin : g_chk
        $error("RST_PULSE_CYC must be at least 1");
    end

    logic [7:0] ptr_ff;
    logic [7:0] pt_ff;
    logic [7:0] cm_ff;
    logic [7:0] cfg_ff;
    logic [7:0] as1_ff;
    logic [7:0] as2_ff;
    logic [7:0] rd_ff;
    logic [31:0] cnt_ff;
    mcs_pkg::mcs_rst_state_e rst_st_ff;
    mcs_pkg::mcs_rst_state_e nxt_rst_st;
    logic [31:0] nxt_cnt;
    logic [2:0] ci_sync_ff;
    logic [2:0] th_sync_ff;
    logic ci_q_ff;
    logic th_low_ff;
    logic [3:0] oe_hist_ff;
    logic ext_wr_ff;
    logic init_ff;
    logic [7:0] set_1_d;

    // Address decode of the pointed register
    wire sel_pt = (ptr_ff == `MCS_OFS_POWER_TEST);
    wire sel_cm = (ptr_ff == `MCS_OFS_CHAN_MODE);
    wire sel_cfg = (ptr_ff == `MCS_OFS_MAIN_CFG);
    wire sel_as1 = (ptr_ff == `MCS_OFS_ALARM_1);
    wire sel_as2 = (ptr_ff == `MCS_OFS_ALARM_2);
    wire own_sel = sel_pt | sel_cm | sel_cfg | sel_as1 | sel_as2;
    wire wr_cfg = I_WR_EN & ~I_PTR_WE & sel_cfg;
    wire init_req = wr_cfg & I_WR_DATA[`MCS_CFG_INIT];
    wire rd_as1 = I_RD_EN & sel_as1;
    wire rd_as2 = I_RD_EN & sel_as2;
    wire pulse_done = (rst_st_ff == mcs_pkg::MCS_RST_PULSE) && (cnt_ff == 32'h0000_0001);

    // Status events; bits 6,7 of the first take fan or analog per mode
    wire [1:0] chan_evt = {cm_ff[`MCS_CM_CH2_ANALOG] ? I_AIN_EVT[1] : I_LIMIT_EVT_1[7],
                           cm_ff[`MCS_CM_CH1_ANALOG] ? I_AIN_EVT[0] : I_LIMIT_EVT_1[6]};
    wire [7:0] set_1 = {chan_evt, I_LIMIT_EVT_1[5:0]};
    wire ci_rise = ci_sync_ff[1] & ci_sync_ff[2] & ~ci_q_ff;
    wire th_ext = th_low_ff & (oe_hist_ff == 4'h0);
    wire [7:0] set_2 = {I_DIODE_FAULT, th_ext, ci_rise, 2'b00, I_LIMIT_EVT_2};

    function automatic logic pending(input logic [7:0] stat, input logic [7:0] mask);
        pending = |(stat & ~mask);
    endfunction

    // Interrupt outputs ignore the start bit so standby never hides an alarm
    wire gen_pend = pending(as1_ff, I_MASK_1) | pending(as2_ff & ~`MCS_AS2_RESERVED_MASK, I_MASK_2);
    wire gen_act = cfg_ff[`MCS_CFG_GEN_EN] & ~cfg_ff[`MCS_CFG_GEN_CLEAR] & gen_pend;
    wire th_act = cfg_ff[`MCS_CFG_THERMAL_IRQ_N_EN] & ~cfg_ff[`MCS_CFG_THERMAL_IRQ_CLEAR] & I_THERMAL_IRQ_N_COND;

    // Address pointer, loaded by the host
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            ptr_ff <= `MCS_RST_PTR;
        end else if (I_PTR_WE) begin
            ptr_ff <= I_WR_DATA;
        end
    end

    // Power/test and channel mode keep their values across initialization
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            pt_ff <= `MCS_RST_POWER_TEST;
            cm_ff <= `MCS_RST_CHAN_MODE;
        end else if (I_WR_EN && !I_PTR_WE) begin
            if (sel_pt) begin
                pt_ff <= I_WR_DATA;
            end
            if (sel_cm) begin
                cm_ff <= I_WR_DATA;
            end
        end
    end

    // Main configuration; the reset bit drops when its pulse ends
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            cfg_ff <= `MCS_RST_MAIN_CFG;
        end else if (init_req) begin
            cfg_ff <= `MCS_RST_MAIN_CFG;
        end else if (wr_cfg) begin
            cfg_ff <= {1'b0, I_WR_DATA[6:0]};
        end else if (pulse_done) begin
            cfg_ff[`MCS_CFG_RESET_OUT] <= 1'b0;
        end
    end

    // Sticky status: a set in the cycle of a clearing read wins; writes never land
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            as1_ff <= `MCS_RST_ALARM;
            as2_ff <= `MCS_RST_ALARM;
        end else if (init_req) begin
            // Defaults return, but an event in the same cycle still lands
            as1_ff <= `MCS_RST_ALARM | set_1;
            as2_ff <= `MCS_RST_ALARM | set_2;
        end else begin
            as1_ff <= (rd_as1 ? 8'h00 : as1_ff) | set_1;
            as2_ff <= (rd_as2 ? 8'h00 : as2_ff) | set_2;
        end
    end

    // Read data and the strobe for registers held outside this block
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rd_ff <= 8'h00;
            ext_wr_ff <= 1'b0;
            init_ff <= 1'b0;
        end else begin
            if (I_RD_EN) begin
                rd_ff <= sel_pt ? pt_ff : sel_cm ? cm_ff : sel_cfg ? cfg_ff : sel_as1 ? as1_ff :
                         sel_as2 ? (as2_ff & ~`MCS_AS2_RESERVED_MASK) : I_EXT_RD_DATA;
            end
            ext_wr_ff <= I_WR_EN & ~I_PTR_WE & ~own_sel;
            init_ff <= init_req;
        end
    end

    // Reset output sequencer: counts the whole pulse, then frees the bit
    always_comb begin
        nxt_rst_st = rst_st_ff;
        nxt_cnt = cnt_ff;
        unique case (rst_st_ff)
            mcs_pkg::MCS_RST_IDLE: begin
                if (wr_cfg && I_WR_DATA[`MCS_CFG_RESET_OUT] && !init_req) begin
                    nxt_rst_st = mcs_pkg::MCS_RST_PULSE;
                    nxt_cnt = RST_PULSE_CYC;
                end
            end
            mcs_pkg::MCS_RST_PULSE: begin
                nxt_cnt = cnt_ff - 32'h0000_0001;
                if (pulse_done) begin
                    nxt_rst_st = mcs_pkg::MCS_RST_IDLE;
                end
            end
            default: begin
                nxt_rst_st = mcs_pkg::MCS_RST_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rst_st_ff <= mcs_pkg::MCS_RST_IDLE;
            cnt_ff <= 32'h0000_0000;
        end else begin
            rst_st_ff <= nxt_rst_st;
            cnt_ff <= nxt_cnt;
        end
    end

    // Pin synchronisers; a level counts once stages two and three agree
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            ci_sync_ff <= 3'h0;
            th_sync_ff <= 3'h7;
            ci_q_ff <= 1'b0;
            th_low_ff <= 1'b0;
            oe_hist_ff <= 4'h0;
        end else begin
            ci_sync_ff <= {ci_sync_ff[1:0], I_CHASSIS_INTRUSION};
            th_sync_ff <= {th_sync_ff[1:0], I_THERMAL_IRQ_N};
            if (ci_sync_ff[1] == ci_sync_ff[2]) begin
                ci_q_ff <= ci_sync_ff[2];
            end
            if (th_sync_ff[1] == th_sync_ff[2]) begin
                th_low_ff <= ~th_sync_ff[2];
            end
            // Our own drive echoes back through the synchroniser, so it is masked
            oe_hist_ff <= {oe_hist_ff[2:0], th_act};
        end
    end

    assign O_RD_DATA = rd_ff;
    assign O_PTR = ptr_ff;
    assign O_EXT_WR = ext_wr_ff;
    assign O_INIT_PULSE = init_ff;
    assign O_GENERAL_IRQ_N = ~gen_act;
    assign O_THERMAL_IRQ_N = 1'b0;
    assign O_THERMAL_IRQ_OE = th_act;
    assign O_SYS_RESET_OUT_N = (rst_st_ff != mcs_pkg::MCS_RST_PULSE);
    assign O_SHUTDOWN = pt_ff[`MCS_PT_SHUTDOWN];
    assign O_MONITOR_RUN = cfg_ff[`MCS_CFG_START] & ~cfg_ff[`MCS_CFG_GEN_CLEAR] & ~pt_ff[`MCS_PT_SHUTDOWN];
    assign O_CH1_ANALOG = cm_ff[`MCS_CM_CH1_ANALOG];
    assign O_CH2_ANALOG = cm_ff[`MCS_CM_CH2_ANALOG];
    assign O_SECOND_DIODE = cm_ff[`MCS_CM_SECOND_DIODE];
    assign O_SUPPLY_5V = cm_ff[`MCS_CM_SUPPLY_5V];
    assign O_ID_OR_IRQ = cm_ff[`MCS_CM_ID_OR_IRQ];
    assign O_EXT_IRQ_EN = cm_ff[`MCS_CM_IRQ_EN_HI:`MCS_CM_IRQ_EN_LO] & {3{cm_ff[`MCS_CM_ID_OR_IRQ]}};

    // Checks on the design's own behaviour
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_ARST_N);

    ptr_load_a: assert property (I_PTR_WE |=> O_PTR == $past(I_WR_DATA))
        else $error("pointer not loaded");
    status_wr_a: assert property (I_WR_EN && !I_PTR_WE && sel_as1 && !I_RD_EN && set_1 == 8'h00
        |=> as1_ff == $past(as1_ff))
        else $error("status changed by write");
    init_def_a: assert property (init_req |=> cfg_ff == `MCS_RST_MAIN_CFG && as1_ff == set_1_d)
        else $error("init did not restore defaults");
    gen_clear_a: assert property (cfg_ff[`MCS_CFG_GEN_CLEAR] |-> O_GENERAL_IRQ_N && !O_MONITOR_RUN)
        else $error("general irq clear failed");
    gen_hold_a: assert property (!O_GENERAL_IRQ_N && wr_cfg && I_WR_DATA[3:1] == 3'b001 && !init_req
        && !I_RD_EN |=> !O_GENERAL_IRQ_N)
        else $error("stop cleared general irq");
    thermal_irq_n_clr_a: assert property (cfg_ff[`MCS_CFG_THERMAL_IRQ_CLEAR] |-> !O_THERMAL_IRQ_OE)
        else $error("thermal irq not cleared");
    rst_start_a: assert property (rst_st_ff == mcs_pkg::MCS_RST_IDLE && wr_cfg && I_WR_DATA[4] && !init_req
        |=> !O_SYS_RESET_OUT_N [*8])
        else $error("reset pulse too short");
    rst_bit_a: assert property (pulse_done |=> O_SYS_RESET_OUT_N && !cfg_ff[`MCS_CFG_RESET_OUT])
        else $error("reset bit not self-cleared");
    ext_irq_a: assert property (!cm_ff[`MCS_CM_ID_OR_IRQ] |-> O_EXT_IRQ_EN == 3'h0)
        else $error("ext irq enabled in id mode");
    chan_sel_a: assert property (cm_ff[0] && I_AIN_EVT[0] && !init_req |=> as1_ff[6])
        else $error("analog event lost");
    shut_run_a: assert property (O_SHUTDOWN |-> !O_MONITOR_RUN)
        else $error("monitoring runs in shutdown");
    gen_off_a: assert property (!cfg_ff[`MCS_CFG_GEN_EN] |-> O_GENERAL_IRQ_N)
        else $error("general irq while disabled");
    stat_set_a: assert property (set_1 != 8'h00 |=> (as1_ff & $past(set_1)) == $past(set_1))
        else $error("limit event lost");
    ci_set_a: assert property (ci_rise |=> as2_ff[`MCS_AS2_INTRUSION])
        else $error("intrusion not latched");
    thermal_irq_n_ext_a: assert property (th_ext |=> as2_ff[`MCS_AS2_THERMAL_IRQ_N_PIN])
        else $error("thermal pull not latched");

    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            set_1_d <= 8'h00;
        end else begin
            set_1_d <= set_1;
        end
    end

    irq_seen_c: cover property (!O_GENERAL_IRQ_N ##1 O_GENERAL_IRQ_N);
    rst_pulse_c: cover property (pulse_done);
    ci_seen_c: cover property (ci_rise);
    init_seen_c: cover property (init_req);
endmodule

// ==== tb/mcs_host_model.sv ====
// Behavioural host that reaches the register port through the address pointer
module mcs_host_model (
    input wire logic i_clock,
    input wire logic [7:0] i_rd_data,
    output logic o_ptr_we,
    output logic o_wr_en,
    output logic o_rd_en,
    output logic [7:0] o_wr_data
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle strobes at time zero
    initial begin
        o_ptr_we = 1'b0;
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_wr_data = 8'h5a;
    end
    // Pointer first, then data; released data shows the inverse so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        o_ptr_we <= 1'b1;
        o_wr_data <= a;
        @(posedge i_clock);
        o_ptr_we <= 1'b0;
        o_wr_en <= 1'b1;
        o_wr_data <= d;
        @(posedge i_clock);
        o_wr_en <= 1'b0;
        o_wr_data <= ~d;
        #1;
    endtask
    // Read answer is registered, so it is taken just after the edge that accepts the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clock);
        o_ptr_we <= 1'b1;
        o_wr_data <= a;
        @(posedge i_clock);
        o_ptr_we <= 1'b0;
        o_rd_en <= 1'b1;
        o_wr_data <= ~a;
        @(posedge i_clock);
        o_rd_en <= 1'b0;
        #1;
        d = i_rd_data;
    endtask
endmodule

// ==== tb/tb_top.sv ====
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned PULSE = 10;
    logic clk, arst_n, ptr_we, wr_en, rd_en;
    logic [7:0] wr_data, rd_data, ptr, ext_rd, evt1, mask1, mask2, got;
    logic [1:0] ain, evt2, dfault;
    logic thermal_irq_n_cond, intrusion, ext_pull, thermal_irq_n_n, thermal_irq_n_oe, gen_n, rst_n, init_p, ext_wr;
    logic shut, run, ch1, ch2, dio, v5, idirq;
    logic [2:0] irq_en;
    logic [7:0] modes [4] = '{8'h0f, 8'hf0, 8'h50, 8'hd5};
    logic [7:0] mexp [4] = '{8'hf0, 8'h0f, 8'h00, 8'had};
    logic [7:0] ofs [5] = '{8'h15, 8'h16, 8'h40, 8'h41, 8'h42};
    logic [7:0] rsts [5] = '{8'h00, 8'h00, 8'h08, 8'h00, 8'h00};
    wire thermal_irq_n_pin;
    int errors, n_checks, i, n;
    // Open-drain thermal wire with pull-up
    assign thermal_irq_n_pin = ((thermal_irq_n_oe && !thermal_irq_n_n) || ext_pull) ? 1'b0 : 1'b1;
    mcs_regs #(.RST_PULSE_CYC(PULSE)) u_dut (.I_CLOCK(clk), .I_ARST_N(arst_n), .I_PTR_WE(ptr_we),
        .I_WR_EN(wr_en), .I_WR_DATA(wr_data), .I_RD_EN(rd_en), .O_RD_DATA(rd_data), .O_PTR(ptr),
        .O_EXT_WR(ext_wr), .I_EXT_RD_DATA(ext_rd), .I_LIMIT_EVT_1(evt1), .I_AIN_EVT(ain),
        .I_LIMIT_EVT_2(evt2), .I_DIODE_FAULT(dfault), .I_MASK_1(mask1), .I_MASK_2(mask2),
        .I_THERMAL_IRQ_N_COND(thermal_irq_n_cond), .I_CHASSIS_INTRUSION(intrusion), .I_THERMAL_IRQ_N(thermal_irq_n_pin),
        .O_THERMAL_IRQ_N(thermal_irq_n_n), .O_THERMAL_IRQ_OE(thermal_irq_n_oe), .O_GENERAL_IRQ_N(gen_n),
        .O_SYS_RESET_OUT_N(rst_n), .O_INIT_PULSE(init_p), .O_SHUTDOWN(shut), .O_MONITOR_RUN(run),
        .O_CH1_ANALOG(ch1), .O_CH2_ANALOG(ch2), .O_SECOND_DIODE(dio), .O_SUPPLY_5V(v5),
        .O_ID_OR_IRQ(idirq), .O_EXT_IRQ_EN(irq_en));
    mcs_host_model u_host (.i_clock(clk), .i_rd_data(rd_data), .o_ptr_we(ptr_we), .o_wr_en(wr_en),
        .o_rd_en(rd_en), .o_wr_data(wr_data));
    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic conclude();
        if (errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string what);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, g, e);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string what);
        u_host.rd(a, got);
        chk(got, e, what);
    endtask
    // One-cycle event pulse on the limit, analog and diode-fault sources at once
    task automatic pulse(input logic [7:0] e1, input logic [1:0] a, input logic [1:0] e2, input logic [1:0] df);
        @(posedge clk);
        evt1 <= e1;
        ain <= a;
        evt2 <= e2;
        dfault <= df;
        @(posedge clk);
        evt1 <= 8'h00;
        ain <= 2'b00;
        evt2 <= 2'b00;
        dfault <= 2'b00;
        #1;
    endtask
    // Main sequence
    initial begin
        arst_n = 1'b0;
        ext_rd = 8'ha5;
        evt1 = 8'h00;
        ain = 2'b00;
        evt2 = 2'b00;
        dfault = 2'b00;
        mask1 = 8'h00;
        mask2 = 8'h00;
        thermal_irq_n_cond = 1'b0;
        intrusion = 1'b0;
        ext_pull = 1'b0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        chk(ptr, 8'h00, "pointer after reset");
        chk({6'h00, gen_n, rst_n}, 8'h03, "outputs idle after reset");
        for (i = 0; i < 5; i++) begin
            rdchk(ofs[i], rsts[i], "reset value");
        end
        chk(ptr, 8'h42, "pointer follows host");
        u_host.wr(8'h15, 8'h01);
        chk({7'h00, shut}, 8'h01, "shutdown set");
        u_host.wr(8'h15, 8'h00);
        chk({7'h00, shut}, 8'h00, "shutdown cleared");
        for (i = 0; i < 4; i++) begin
            u_host.wr(8'h16, modes[i]);
            chk({4'h0, ch1, ch2, dio, v5}, {4'h0, mexp[i][7:4]}, "modes");
            chk({4'h0, idirq, irq_en}, {4'h0, mexp[i][3:0]}, "irq modes");
            rdchk(8'h16, modes[i], "mode readback");
        end
        // Channel 1 analog, channel 2 fan: each status bit must follow only its selected source
        u_host.wr(8'h16, 8'h01);
        pulse(8'h40, 2'b10, 2'b00, 2'b00);
        rdchk(8'h41, 8'h00, "unselected sources");
        pulse(8'h80, 2'b01, 2'b00, 2'b00);
        rdchk(8'h41, 8'hc0, "selected sources");
        // Limits sit outside this block, so the start bit may be set at once
        u_host.wr(8'h40, 8'h01);
        chk({7'h00, run}, 8'h01, "monitoring started");
        pulse(8'h04, 2'b00, 2'b00, 2'b00);
        chk({7'h00, gen_n}, 8'h01, "general irq disabled");
        u_host.wr(8'h40, 8'h03);
        chk({7'h00, gen_n}, 8'h00, "general irq pending");
        u_host.wr(8'h40, 8'h02);
        chk({6'h00, run, gen_n}, 8'h00, "standby keeps irq");
        u_host.wr(8'h40, 8'h0b);
        chk({6'h00, run, gen_n}, 8'h01, "irq clear halts");
        rdchk(8'h41, 8'h04, "status kept by clear");
        u_host.wr(8'h40, 8'h02);
        @(posedge clk);
        mask1 <= 8'h04;
        pulse(8'h04, 2'b00, 2'b00, 2'b00);
        chk({7'h00, gen_n}, 8'h01, "masked bit");
        pulse(8'h3f, 2'b00, 2'b00, 2'b00);
        chk({7'h00, gen_n}, 8'h00, "unmasked bits");
        rdchk(8'h41, 8'h3f, "limit status");
        chk({7'h00, gen_n}, 8'h01, "irq gone after read");
        // Second status group, pins held long enough to pass the input filter
        pulse(8'h00, 2'b00, 2'b11, 2'b11);
        @(posedge clk);
        intrusion <= 1'b1;
        repeat (10) @(posedge clk);
        intrusion <= 1'b0;
        ext_pull <= 1'b1;
        repeat (10) @(posedge clk);
        ext_pull <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        chk({7'h00, gen_n}, 8'h00, "second group irq");
        @(posedge clk);
        mask2 <= 8'hf3;
        #1;
        chk({7'h00, gen_n}, 8'h01, "second group masked");
        @(posedge clk);
        mask2 <= 8'h00;
        rdchk(8'h42, 8'hf3, "second status");
        u_host.wr(8'h42, 8'hff);
        rdchk(8'h42, 8'h00, "status write ignored");
        u_host.wr(8'h41, 8'hff);
        rdchk(8'h41, 8'h00, "first status write ignored");
        u_host.wr(8'h43, 8'h11);
        chk({7'h00, ext_wr}, 8'h01, "outside write strobe");
        rdchk(8'h43, 8'ha5, "outside read");
        // Thermal output: enable, then clear, then disable
        @(posedge clk);
        thermal_irq_n_cond <= 1'b1;
        u_host.wr(8'h40, 8'h04);
        chk({6'h00, thermal_irq_n_oe, thermal_irq_n_n}, 8'h02, "thermal driven");
        u_host.wr(8'h40, 8'h44);
        chk({7'h00, thermal_irq_n_oe}, 8'h00, "thermal cleared");
        u_host.wr(8'h40, 8'h00);
        chk({7'h00, thermal_irq_n_oe}, 8'h00, "thermal disabled");
        @(posedge clk);
        thermal_irq_n_cond <= 1'b0;
        rdchk(8'h42, 8'h00, "own drive not latched");
        u_host.wr(8'h40, 8'h10);
        n = 0;
        while (rst_n !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 100) begin
            errors++;
            conclude();
        end
        chk({7'h00, 1'(n >= PULSE && n <= PULSE + 1)}, 8'h01, "reset pulse length");
        rdchk(8'h40, 8'h00, "reset bit self-clears");
        u_host.wr(8'h40, 8'h03);
        pulse(8'h01, 2'b00, 2'b00, 2'b00);
        u_host.wr(8'h40, 8'h80);
        chk({6'h00, init_p, gen_n}, 8'h03, "init pulse");
        rdchk(8'h40, 8'h08, "init restores config");
        rdchk(8'h41, 8'h00, "init clears status");
        // Second reset in mid-run returns the registers to their defaults
        u_host.wr(8'h16, 8'h8f);
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        chk(ptr, 8'h00, "pointer after second reset");
        chk({1'b0, idirq, ch1, irq_en, rst_n, gen_n}, 8'h03, "outputs after second reset");
        rdchk(8'h16, 8'h00, "mode after second reset");
        conclude();
    end
endmodule
